// ---- rtl/wdt_pkg.sv ----
// Constants for the watchdog timer and reset cause flags
package wdt_pkg;
    // ========================================================
    // Bus and register map
    localparam int          APB_DW         = 32;
    localparam int          ADDR_W         = 12;
    localparam int          REG_W          = 8;
    localparam logic [9:0]  STAT_IDX       = 10'h035;
    localparam logic [9:0]  CTRL_IDX       = 10'h060;
    localparam logic [ADDR_W-1:0] STAT_ADDR = {STAT_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
    // ========================================================
    // Reset cause status bits
    localparam int          ST_WDOG        = 3;
    localparam int          ST_BROWN       = 2;
    localparam int          ST_PIN         = 1;
    localparam int          ST_POR         = 0;
    localparam logic [3:0]  ST_UNUSED      = 4'h0;
    // ========================================================
    // Watchdog control status bits
    localparam int          CT_IRQF        = 7;
    localparam int          CT_IRQE        = 6;
    localparam int          CT_P_HI        = 5;
    localparam int          CT_CE          = 4;
    localparam int          CT_WDE         = 3;
    localparam int          CT_P_LO_MSB    = 2;
    localparam int          PSEL_W         = 4;
    localparam logic [PSEL_W-1:0] PSEL_MAX = 4'h9;
    localparam logic [PSEL_W-1:0] PSEL_RST = 4'h0;
    // ========================================================
    // Timing
    localparam int          CLK_PERIOD_NS  = 100;
    localparam int          OSC_FREQ_KHZ   = 128;
    localparam int          BASE_OSC_CYC   = 2048;
    localparam int          CE_HOLD_CYC    = 4;
    localparam logic [1:0]  CE_CNT_LOAD    = 2'(CE_HOLD_CYC - 1);
    // ========================================================
    // Input synchroniser lanes
    localparam int          SY_OSC         = 0;
    localparam int          SY_BROWN       = 1;
    localparam int          SY_PIN         = 2;
    localparam int          SY_FUSE        = 3;
    localparam int          SY_N           = 4;
    localparam logic [SY_N-1:0] SY_RST     = 4'h8;
endpackage : wdt_pkg

// ---- rtl/wdt_cnt_if.sv ----
// Link between the watchdog control logic and its time-out counter
`timescale 1ns/10ps
`default_nettype none
interface wdt_cnt_if;
    logic       restart;
    logic       run;
    logic [3:0] period_sel;
    logic       osc_lvl;
    logic       timeout;
    modport core (output restart, output run, output period_sel, output osc_lvl, input timeout);
    modport cnt  (input restart, input run, input period_sel, input osc_lvl, output timeout);
endinterface : wdt_cnt_if
`default_nettype wire

// ---- rtl/wdt_timeout_counter.sv ----
// Oscillator cycle counter with selectable time-out
`timescale 1ns/10ps
`default_nettype none
module wdt_timeout_counter
    import wdt_pkg::*;
#(
    parameter int BASE_CYCLES = BASE_OSC_CYC
)(
    input  wire logic clk,
    input  wire logic rst_b,
    wdt_cnt_if.cnt    cif
);
    localparam int CW = $clog2(BASE_CYCLES) + 10;

    logic          osc_prev_r;
    logic          osc_prev_nxt;
    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;
    logic          timeout_r;
    logic          timeout_nxt;
    logic [3:0]    sel_eff;
    logic [CW-1:0] limit;
    logic          tick;

    // ========================================================
    // Counting
    always_comb
    begin
        // Reserved codes run at the longest period
        sel_eff      = (cif.period_sel > PSEL_MAX) ? PSEL_MAX : cif.period_sel;
        limit        = CW'(BASE_CYCLES) << sel_eff;
        tick         = cif.osc_lvl & ~osc_prev_r;
        osc_prev_nxt = cif.osc_lvl;
        count_nxt    = count_r;
        timeout_nxt  = 1'b0;
        if (cif.restart || !cif.run)
        begin
            count_nxt = '0;
        end
        else if (tick)
        begin
            if (count_r == limit - CW'(1))
            begin
                count_nxt   = '0;
                timeout_nxt = 1'b1;
            end
            else
            begin
                count_nxt = count_r + CW'(1);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            osc_prev_r <= 1'b0;
            count_r    <= '0;
            timeout_r  <= 1'b0;
        end
        else
        begin
            osc_prev_r <= osc_prev_nxt;
            count_r    <= count_nxt;
            timeout_r  <= timeout_nxt;
        end
    end

    assign cif.timeout = timeout_r;

    // ========================================================
    // Checks
    a_restart_after_to: assert property (@(posedge clk) disable iff (!rst_b)
        timeout_r |-> count_r == '0)
        else $error("counter did not restart after time-out");
endmodule : wdt_timeout_counter
`default_nettype wire

// ---- rtl/wdt_core.sv ----
// Watchdog timer with reset cause flags behind an APB slave
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module wdt_core
    import wdt_pkg::*;
#(
    parameter int BASE_CYCLES = BASE_OSC_CYC
)(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [APB_DW-1:0] pwdata,
    output logic      [APB_DW-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              osc_128k_in,
    input  wire logic              brownout_rst_in,
    input  wire logic              pin_rst_in,
    input  wire logic              always_on_fuse,
    input  wire logic              global_irq_enable,
    input  wire logic              vector_ack,
    input  wire logic              wdog_restart,
    output logic                   wdog_irq_req,
    output logic                   wdog_sys_reset
);
    wdt_cnt_if cif ();

    // ========================================================
    // Input synchronisers
    logic [SY_N-1:0] sync1_r;
    logic [SY_N-1:0] sync2_r;
    logic [SY_N-1:0] sync_in;

    assign sync_in = {always_on_fuse, pin_rst_in, brownout_rst_in, osc_128k_in};

    generate
        for (genvar i = 0; i < SY_N; i++)
        begin : g_sync
            always_ff @(posedge clk)
            begin
                if (!rst_b)
                begin
                    sync1_r[i] <= SY_RST[i];
                    sync2_r[i] <= SY_RST[i];
                end
                else
                begin
                    sync1_r[i] <= sync_in[i];
                    sync2_r[i] <= sync1_r[i];
                end
            end
        end
    endgenerate

    // ========================================================
    // APB slave
    logic              pready_r;
    logic              pready_nxt;
    logic [APB_DW-1:0] prdata_r;
    logic [APB_DW-1:0] prdata_nxt;
    logic              pslverr_r;
    logic              pslverr_nxt;
    logic              hit_stat;
    logic              hit_ctrl;
    logic              done;
    logic              wr_stat;
    logic              wr_ctrl;
    logic [REG_W-1:0]  stat_val;
    logic [REG_W-1:0]  ctrl_val;

    assign hit_stat = (paddr == STAT_ADDR);
    assign hit_ctrl = (paddr == CTRL_ADDR);
    assign done     = psel & penable & pready_r;
    assign wr_stat  = done & pwrite & hit_stat;
    assign wr_ctrl  = done & pwrite & hit_ctrl;

    always_comb
    begin
        pready_nxt  = 1'b0;
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        if (psel && penable && !pready_r)
        begin
            pready_nxt  = 1'b1;
            pslverr_nxt = ~(hit_stat | hit_ctrl);
            prdata_nxt  = '0;
            if (!pwrite && hit_stat)
            begin
                prdata_nxt = APB_DW'(stat_val);
            end
            else if (!pwrite && hit_ctrl)
            begin
                prdata_nxt = APB_DW'(ctrl_val);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pready_r  <= 1'b0;
            prdata_r  <= '0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= pready_nxt;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // ========================================================
    // Watchdog control and reset cause flags
    logic              por_r,    por_nxt;
    logic              pin_r,    pin_nxt;
    logic              bor_r,    bor_nxt;
    logic              wdog_reset_cause_flag_r,   wdog_reset_cause_flag_nxt;
    logic              irqf_r,   irqf_nxt;
    logic              irqe_r,   irqe_nxt;
    logic              ce_r,     ce_nxt;
    logic [1:0]        ce_cnt_r, ce_cnt_nxt;
    logic              wde_r,    wde_nxt;
    logic [PSEL_W-1:0] period_r, period_nxt;
    logic              bor_prev_r;
    logic              pin_prev_r;
    logic              rst_pulse_r, rst_pulse_nxt;
    logic              irq_req_r,   irq_req_nxt;
    logic              bor_evt;
    logic              pin_evt;
    logic              sys_evt;
    logic              fuse_prog;
    logic              to_irq;
    logic              to_rst;

    assign stat_val  = {ST_UNUSED, wdog_reset_cause_flag_r, bor_r, pin_r, por_r};
    assign ctrl_val  = {irqf_r, irqe_r, period_r[3], ce_r, wde_r, period_r[2:0]};
    assign bor_evt   = sync2_r[SY_BROWN] & ~bor_prev_r;
    assign pin_evt   = sync2_r[SY_PIN] & ~pin_prev_r;
    assign sys_evt   = bor_evt | pin_evt | rst_pulse_r;
    assign fuse_prog = ~sync2_r[SY_FUSE];
    // Combined mode escalates when the flag is still pending
    assign to_irq    = cif.timeout & irqe_r & ~(wde_r & irqf_r);
    assign to_rst    = cif.timeout & wde_r & (~irqe_r | irqf_r);

    always_comb
    begin
        por_nxt       = por_r;
        pin_nxt       = pin_r;
        bor_nxt       = bor_r;
        wdog_reset_cause_flag_nxt      = wdog_reset_cause_flag_r;
        irqf_nxt      = irqf_r;
        irqe_nxt      = irqe_r;
        ce_nxt        = ce_r;
        ce_cnt_nxt    = ce_cnt_r;
        wde_nxt       = wde_r;
        period_nxt    = period_r;
        rst_pulse_nxt = 1'b0;
        irq_req_nxt   = irqf_r & irqe_r & global_irq_enable;
        if (ce_r)
        begin
            if (ce_cnt_r == 2'h0)
            begin
                ce_nxt = 1'b0;
            end
            else
            begin
                ce_cnt_nxt = ce_cnt_r - 2'h1;
            end
        end
        if (wr_stat)
        begin
            if (!pwdata[ST_WDOG])
            begin
                wdog_reset_cause_flag_nxt = 1'b0;
            end
            if (!pwdata[ST_BROWN])
            begin
                bor_nxt = 1'b0;
            end
            if (!pwdata[ST_PIN])
            begin
                pin_nxt = 1'b0;
            end
            if (!pwdata[ST_POR])
            begin
                por_nxt = 1'b0;
            end
        end
        if (wr_ctrl)
        begin
            if (pwdata[CT_IRQF])
            begin
                irqf_nxt = 1'b0;
            end
            irqe_nxt = pwdata[CT_IRQE];
            if (ce_r)
            begin
                wde_nxt    = pwdata[CT_WDE];
                period_nxt = {pwdata[CT_P_HI], pwdata[CT_P_LO_MSB:0]};
            end
            else if (pwdata[CT_WDE])
            begin
                wde_nxt = 1'b1;
            end
            if (!ce_r && pwdata[CT_CE])
            begin
                ce_nxt     = 1'b1;
                ce_cnt_nxt = CE_CNT_LOAD;
            end
        end
        if (vector_ack)
        begin
            irqf_nxt = 1'b0;
            if (wde_r)
            begin
                irqe_nxt = 1'b0;
            end
        end
        // Any system reset returns the control register to its reset state except wde_r, which a set watchdog cause flag or the fuse holds at 1,
        // and irqf_r, which a time-out interrupt in the same cycle sets to 1
        if (sys_evt)
        begin
            irqf_nxt   = 1'b0;
            irqe_nxt   = 1'b0;
            ce_nxt     = 1'b0;
            ce_cnt_nxt = 2'h0;
            wde_nxt    = 1'b0;
            period_nxt = PSEL_RST;
        end
        if (bor_evt)
        begin
            bor_nxt = 1'b1;
        end
        if (pin_evt)
        begin
            pin_nxt = 1'b1;
        end
        if (to_irq)
        begin
            irqf_nxt = 1'b1;
        end
        if (to_rst)
        begin
            rst_pulse_nxt = 1'b1;
            wdog_reset_cause_flag_nxt      = 1'b1;
        end
        if (wdog_reset_cause_flag_nxt)
        begin
            wde_nxt = 1'b1;
        end
        if (fuse_prog)
        begin
            wde_nxt  = 1'b1;
            irqe_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            por_r       <= 1'b1;
            pin_r       <= 1'b0;
            bor_r       <= 1'b0;
            wdog_reset_cause_flag_r      <= 1'b0;
            irqf_r      <= 1'b0;
            irqe_r      <= 1'b0;
            ce_r        <= 1'b0;
            ce_cnt_r    <= 2'h0;
            wde_r       <= 1'b0;
            period_r    <= PSEL_RST;
            bor_prev_r  <= 1'b0;
            pin_prev_r  <= 1'b0;
            rst_pulse_r <= 1'b0;
            irq_req_r   <= 1'b0;
        end
        else
        begin
            por_r       <= por_nxt;
            pin_r       <= pin_nxt;
            bor_r       <= bor_nxt;
            wdog_reset_cause_flag_r      <= wdog_reset_cause_flag_nxt;
            irqf_r      <= irqf_nxt;
            irqe_r      <= irqe_nxt;
            ce_r        <= ce_nxt;
            ce_cnt_r    <= ce_cnt_nxt;
            wde_r       <= wde_nxt;
            period_r    <= period_nxt;
            bor_prev_r  <= sync2_r[SY_BROWN];
            pin_prev_r  <= sync2_r[SY_PIN];
            rst_pulse_r <= rst_pulse_nxt;
            irq_req_r   <= irq_req_nxt;
        end
    end

    assign wdog_irq_req   = irq_req_r;
    assign wdog_sys_reset = rst_pulse_r;

    // ========================================================
    // Time-out counter
    assign cif.restart    = wdog_restart | sys_evt;
    assign cif.run        = wde_r | irqe_r;
    assign cif.period_sel = period_r;
    assign cif.osc_lvl    = sync2_r[SY_OSC];

    wdt_timeout_counter #(
        .BASE_CYCLES (BASE_CYCLES)
    ) u_counter (
        .clk   (clk),
        .rst_b (rst_b),
        .cif   (cif)
    );

    // ========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_ce_window;
        ce_r [*3] ##1 !ce_r;
    endsequence

    a_ce_self_clear: assert property (
        $rose(ce_r) |=> s_ce_window)
        else $error("change enable did not clear after four cycles");
    a_wdog_reset_cause_flag_holds_wde: assert property (
        wdog_reset_cause_flag_r |-> wde_r)
        else $error("reset enable low while watchdog cause flag set");
    a_status_upper_zero: assert property (
        $rose(pready_r) && !pwrite && hit_stat |-> prdata_r[7:4] == ST_UNUSED)
        else $error("unused status bits read nonzero");
    a_irq_request_gate: assert property (
        irq_req_r |-> $past(irqf_r) && $past(irqe_r) && $past(global_irq_enable))
        else $error("interrupt requested without flag and enables");
    a_rst_pulse_one: assert property (
        rst_pulse_r |=> !rst_pulse_r)
        else $error("system reset pulse longer than one cycle");
    a_rst_sets_flag: assert property (
        rst_pulse_r |-> wdog_reset_cause_flag_r)
        else $error("watchdog reset without cause flag");
    a_period_locked: assert property (
        !$stable(period_r) |-> $past(ce_r) || $past(sys_evt))
        else $error("period changed outside change window");
    a_fuse_reset_mode: assert property (
        $past(fuse_prog) && fuse_prog |-> wde_r && !irqe_r)
        else $error("fuse programmed but not in reset mode");
    a_timeout_irq_flag: assert property (
        cif.timeout && irqe_r && !wde_r && !vector_ack && !sys_evt |=> irqf_r)
        else $error("time-out in interrupt mode did not set flag");
    a_combined_escalate: assert property (
        cif.timeout && wde_r && irqe_r && irqf_r |=> rst_pulse_r)
        else $error("unserviced interrupt did not escalate to reset");
    a_vector_clears: assert property (
        vector_ack && wde_r && !cif.timeout && !fuse_prog |=> !irqf_r && !irqe_r)
        else $error("vector did not clear flag and enable");
endmodule : wdt_core
`default_nettype wire

// ---- tb/wdt_core_tb_top.sv ----
// Self-checking testbench for the watchdog timer with reset cause flags
`timescale 1ns/10ps
`default_nettype none
module wdt_core_tb_top;
    import wdt_pkg::*;
    // ========================================================
    // Signals
    typedef struct {logic wr; logic [ADDR_W-1:0] a; logic [7:0] d; logic [7:0] e; logic er;} wdt_row_s;
    logic              clk;
    logic              rst_b;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
    logic [APB_DW-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              osc_128k_in;
    logic              brownout_rst_in;
    logic              pin_rst_in;
    logic              always_on_fuse;
    logic              global_irq_enable;
    logic              vector_ack;
    logic              wdog_restart;
    logic              wdog_irq_req;
    logic              wdog_sys_reset;
    logic              srst_q;
    int                err_total;
    int                num_checks;
    int                cyc;
    int                rst_seen;
    int                r0;
    logic [31:0]       rd;
    logic              er;
    wdt_row_s          rows [16];

    // Period code 0 lasts 8 oscillator edges, i.e. 64 clocks
    wdt_core #(.BASE_CYCLES(8)) u_wdt_core (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_128k_in(osc_128k_in), .brownout_rst_in(brownout_rst_in), .pin_rst_in(pin_rst_in),
        .always_on_fuse(always_on_fuse), .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
        .wdog_restart(wdog_restart), .wdog_irq_req(wdog_irq_req), .wdog_sys_reset(wdog_sys_reset));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ========================================================
    // Helpers
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        // Hold the access phase until the slave answers; only the bench timeout ends a hang
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string nm, input logic [ADDR_W-1:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(nm, {24'h0, e}, rd);
    endtask : rdchk

    task automatic wait_ev(input logic for_rst, input int lim);
        int n;
        int b;
        n = 0;
        b = rst_seen;
        while (n < lim && (for_rst ? rst_seen == b : wdog_irq_req !== 1'b1))
        begin
            @(posedge clk);
            n++;
        end
        chk(for_rst ? "sys_reset seen" : "irq_req seen", 32'h1, {31'h0, n < lim});
    endtask : wait_ev

    task automatic pulse_ack();
        vector_ack <= 1'b1;
        @(posedge clk);
        vector_ack <= 1'b0;
    endtask : pulse_ack

    // ========================================================
    // Oscillator, reset pulse monitor and timeout
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc % 4 == 3)
            osc_128k_in <= ~osc_128k_in;
        if (wdog_sys_reset === 1'b1)
            rst_seen <= rst_seen + 1;
        if (wdog_sys_reset === 1'b1 && srst_q === 1'b1)
        begin
            err_total++;
            $display("[ERR] sys_reset width expected 1 seen 2");
        end
        srst_q <= wdog_sys_reset;
        if (cyc == 20000)
        begin
            err_total++;
            final_report();
        end
    end

    // ========================================================
    // Main sequence
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, brownout_rst_in, pin_rst_in} = '0;
        {global_irq_enable, vector_ack, wdog_restart, srst_q, osc_128k_in} = '0;
        {always_on_fuse, rst_b} = 2'b10;
        {err_total, num_checks, cyc, rst_seen} = '0;
        rows = '{
            '{0, STAT_ADDR, 8'h00, 8'h01, 0},
            '{0, CTRL_ADDR, 8'h00, 8'h00, 0},
            '{1, STAT_ADDR, 8'hf1, 8'h00, 0},
            '{0, STAT_ADDR, 8'h00, 8'h01, 0},
            '{1, STAT_ADDR, 8'h00, 8'h00, 0},
            '{0, STAT_ADDR, 8'h00, 8'h00, 0},
            '{0, 12'h004,   8'h00, 8'h00, 1},
            '{1, CTRL_ADDR, 8'h47, 8'h00, 0},
            '{0, CTRL_ADDR, 8'h00, 8'h40, 0},
            '{1, CTRL_ADDR, 8'h18, 8'h00, 0},
            '{1, CTRL_ADDR, 8'h29, 8'h00, 0},
            '{0, CTRL_ADDR, 8'h00, 8'h29, 0},
            '{1, CTRL_ADDR, 8'h18, 8'h00, 0},
            '{0, CTRL_ADDR, 8'h00, 8'h39, 0},
            '{0, CTRL_ADDR, 8'h00, 8'h29, 0},
            '{1, CTRL_ADDR, 8'h00, 8'h08, 0}};
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            chk("pslverr", {31'h0, rows[i].er}, {31'h0, er});
            if (!rows[i].wr)
                chk("read data", {24'h0, rows[i].e}, rd);
        end
        rdchk("ctrl kept", CTRL_ADDR, 8'h29);
        wdog_restart <= 1'b1;
        @(posedge clk);
        wdog_restart <= 1'b0;
        apb(1'b1, CTRL_ADDR, 8'h18);
        apb(1'b1, CTRL_ADDR, 8'h00);
        rdchk("ctrl off", CTRL_ADDR, 8'h00);
        $display("test register rows done");
        pin_rst_in <= 1'b1;
        repeat (4) @(posedge clk);
        pin_rst_in <= 1'b0;
        brownout_rst_in <= 1'b1;
        repeat (4) @(posedge clk);
        brownout_rst_in <= 1'b0;
        repeat (6) @(posedge clk);
        rdchk("pin and brownout", STAT_ADDR, 8'h06);
        apb(1'b1, STAT_ADDR, 8'h00);
        rdchk("status cleared", STAT_ADDR, 8'h00);
        $display("test reset events done");
        global_irq_enable <= 1'b1;
        apb(1'b1, CTRL_ADDR, 8'h40);
        wait_ev(1'b0, 300);
        rdchk("irq flag", CTRL_ADDR, 8'hc0);
        global_irq_enable <= 1'b0;
        repeat (3) @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, wdog_irq_req});
        global_irq_enable <= 1'b1;
        pulse_ack();
        repeat (2) @(posedge clk);
        chk("irq after ack", 32'h0, {31'h0, wdog_irq_req});
        rdchk("flag cleared", CTRL_ADDR, 8'h40);
        wait_ev(1'b0, 300);
        apb(1'b1, CTRL_ADDR, 8'h80);
        rdchk("flag write one", CTRL_ADDR, 8'h00);
        $display("test interrupt mode done");
        apb(1'b1, CTRL_ADDR, 8'h48);
        wait_ev(1'b0, 300);
        pulse_ack();
        rdchk("combined ack", CTRL_ADDR, 8'h08);
        wait_ev(1'b1, 300);
        rdchk("wdog cause", STAT_ADDR, 8'h08);
        apb(1'b1, CTRL_ADDR, 8'h48);
        wait_ev(1'b0, 300);
        wait_ev(1'b1, 300);
        apb(1'b1, CTRL_ADDR, 8'h18);
        apb(1'b1, CTRL_ADDR, 8'h00);
        rdchk("enable held", CTRL_ADDR, 8'h08);
        apb(1'b1, STAT_ADDR, 8'h00);
        apb(1'b1, CTRL_ADDR, 8'h18);
        apb(1'b1, CTRL_ADDR, 8'h00);
        rdchk("enable freed", CTRL_ADDR, 8'h00);
        $display("test combined mode done");
        always_on_fuse <= 1'b0;
        repeat (6) @(posedge clk);
        rdchk("fuse forces reset", CTRL_ADDR, 8'h08);
        r0 = rst_seen;
        repeat (6)
        begin
            repeat (40) @(posedge clk);
            wdog_restart <= 1'b1;
            @(posedge clk);
            wdog_restart <= 1'b0;
        end
        chk("restart holds off", r0, rst_seen);
        wait_ev(1'b1, 300);
        rdchk("fuse reset cause", STAT_ADDR, 8'h08);
        $display("test fuse and restart done");
        always_on_fuse <= 1'b1;
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rdchk("power-on flags", STAT_ADDR, 8'h01);
        rdchk("power-on control", CTRL_ADDR, 8'h00);
        $display("test power-on reset done");
        final_report();
    end
endmodule : wdt_core_tb_top
`default_nettype wire
